// [src/pom_pkg.sv]
// package of constants and carrier types for the port mode multiplexer
// Functional notes
// RULE1: control bit zero selects microcontroller I/O mode
// RULE2: output pin in that mode drives data register
// RULE3: input pin readable through the data-in path
// RULE4: ports C, D lack control; default MCU I/O
// RULE5: logic-array output tri-stated unless enable term/direction
// RULE6: host never sets direction on logic inputs
// RULE7: address out needs control with direction or enable
// RULE8: host sets address-out bits after internal boot
// RULE9: non-multiplexed bus puts a7..a0 on port B
// RULE10: address nibble placement depends on host bus type
// RULE11: address inputs captured in input macrocells on strobe
// RULE12: decode-logic inputs are treated as address inputs
// RULE13: data port mode: port A carries host data
// RULE14: memory-mapping bit 7 makes port A peripheral buffer
// RULE15: peripheral buffer tri-stated without a peripheral select
// RULE16: pin output when direction OR enable term true
// RULE17: test-access pins on port C shared with I/O
// RULE18: test port enabled by term, option or bit
// RULE19: direction one means output, zero input, default input
// RULE20: configuration registers read zero after reset
// RULE21: latched address updates on strobe, holds between; with BUS_NONMUX the latch loads every cycle instead
// RULE22: priority: data, peripheral, address, macrocell, data out
package pom_pkg;
   localparam int unsigned PORT_W      = 8;      // width of ports A, B, C
   localparam int unsigned PORTD_W     = 3;      // width of port D
   localparam int unsigned ADDR_W      = 16;     // host address width
   localparam logic [7:0]  REG_RST     = 8'h00;  // configuration reset value
   localparam logic [7:0]  PORTD_MASK  = 8'h07;  // live bits of port D
   localparam int unsigned MEMMAP_PERIPH_BIT = 7; // peripheral enable bit
   localparam logic [7:0]  NIB_LO      = 8'h0F;  // low nibble mask
   localparam logic [7:0]  NIB_HI      = 8'hF0;  // high nibble mask
   localparam logic [7:0]  NIB_ALL     = 8'hFF;  // both nibbles
   localparam logic [7:0]  NIB_NONE    = 8'h00;  // no address bits

   // port indices into the per-port register arrays
   localparam int unsigned PA = 0;
   localparam int unsigned PB = 1;
   localparam int unsigned PC = 2;
   localparam int unsigned PD = 3;

   // host bus flavours that shape the address-out nibble map
   typedef enum logic [1:0] {
      BUS_MUX_GENERIC,  // generic 8-bit multiplexed host
      BUS_MUX_WIDE,     // wide-address 8-bit multiplexed host
      BUS_MUX_PAGED,    // paged multiplexed host
      BUS_NONMUX        // non-multiplexed 8-bit host
   } pom_bus_t;

   // register selector for host access
   typedef enum logic [4:0] {
      SEL_CTL_A, SEL_CTL_B,
      SEL_DIR_A, SEL_DIR_B, SEL_DIR_C, SEL_DIR_D,
      SEL_DRV_A, SEL_DRV_B, SEL_DRV_C, SEL_DRV_D,
      SEL_OUT_A, SEL_OUT_B, SEL_OUT_C, SEL_OUT_D,
      SEL_IN_A,  SEL_IN_B,  SEL_IN_C,  SEL_IN_D,
      SEL_EN_A,  SEL_EN_B,  SEL_EN_C,  SEL_EN_D,
      SEL_MEMMAP
   } pom_reg_sel_t;

   // one host register request
   typedef struct packed {
      logic         wr;     // write strobe
      pom_reg_sel_t sel;    // register addressed
      logic [7:0]   wdata;  // write data
   } pom_reg_req_t;

   // logic-array terms for one 8-bit port
   typedef struct packed {
      logic [7:0] oe_term;  // output enable product terms
      logic [7:0] mc_out;   // output macrocell values
      logic [7:0] mc_def;   // pin assigned a logic equation
      logic [7:0] addr_in;  // pin configured as address input
      logic [7:0] dec_use;  // pin used in memory decode equations
   } pom_pld_t;
endpackage

// [src/pom_port_drv.sv]
// per-port output multiplexer and driver enable, combinational
`timescale 1ns/1ps
`default_nettype none
module pom_port_drv #(
   parameter int unsigned W = 8       // pins in this port
) (
   input  wire logic [W-1:0] dir_i,      // direction register
   input  wire logic [W-1:0] ctl_i,      // control register, 0 on C/D
   input  wire logic [W-1:0] dout_i,     // output data register
   input  wire logic [W-1:0] oe_term_i,  // enable product terms
   input  wire logic [W-1:0] mc_out_i,   // macrocell outputs
   input  wire logic [W-1:0] mc_def_i,   // pin owned by logic array
   input  wire logic [W-1:0] addr_i,     // latched address bits
   input  wire logic [W-1:0] addr_ok_i,  // address bit defined here
   input  wire logic [W-1:0] force_in_i, // pin held as input
   output logic      [W-1:0] out_o,      // value for the pin
   output logic      [W-1:0] oe_o        // driver enable, high drives
);
   logic [W-1:0] addr_sel;  // pin in address out mode

   // control one with direction or term picks address out on defined bits; zero leaves MCU I/O or macrocell
   assign addr_sel = ctl_i & addr_ok_i & (dir_i | oe_term_i); // see RULE7

   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (addr_sel[i]) begin
            out_o[i] = addr_i[i];                 // see RULE22
         end else if (mc_def_i[i]) begin
            out_o[i] = mc_out_i[i];               // see RULE5
         end else begin
            out_o[i] = dout_i[i];                 // see RULE1 see RULE2
         end
      end
      oe_o = (dir_i | oe_term_i) & ~force_in_i;   // see RULE16 see RULE19
   end
endmodule
`default_nettype wire

// [src/pom_port_mux.sv]
// port operating-mode selection and pin multiplexing for ports A to D
`timescale 1ns/1ps
`default_nettype none
module pom_port_mux #(
   parameter logic [7:0] JTAG_PINS = 8'h0F  // port C pins of test port
) (
   input  wire logic                clk_i,        // bus clock, 200 MHz
   input  wire logic                sys_rst_i,    // synchronous reset
   input  wire pom_pkg::pom_reg_req_t reg_req_i,  // register access
   output logic               [7:0] reg_rdata_o,  // register read data
   input  wire pom_pkg::pom_bus_t   bus_type_i,   // host bus flavour
   input  wire logic [pom_pkg::ADDR_W-1:0] host_addr_i, // host address
   input  wire logic                addr_strobe_i,  // address latch strobe
   input  wire logic          [7:0] host_data_i,  // host write data
   input  wire logic                host_wr_i,    // host write cycle
   output logic               [7:0] host_data_o,  // port A to host
   input  wire logic                data_port_en_i, // port A is data port
   input  wire logic                psel_a_i,     // peripheral select a
   input  wire logic                psel_b_i,     // peripheral select b
   input  wire pom_pkg::pom_pld_t   pld_a_i,      // logic terms port A
   input  wire pom_pkg::pom_pld_t   pld_b_i,      // logic terms port B
   input  wire pom_pkg::pom_pld_t   pld_c_i,      // logic terms port C
   input  wire pom_pkg::pom_pld_t   pld_d_i,      // logic terms port D
   input  wire logic                test_sel_term_i, // test select term
   input  wire logic                test_cfg_en_i,   // programmed option
   input  wire logic                test_run_en_i,   // run-time enable
   output logic                     test_port_en_o,  // test pins owned
   input  wire logic          [7:0] pa_i,         // port A pins in
   output logic               [7:0] pa_o,         // port A pins out
   output logic               [7:0] pa_oe_n_o,    // port A enable, low
   input  wire logic          [7:0] pb_i,         // port B pins in
   output logic               [7:0] pb_o,         // port B pins out
   output logic               [7:0] pb_oe_n_o,    // port B enable, low
   input  wire logic          [7:0] pc_i,         // port C pins in
   output logic               [7:0] pc_o,         // port C pins out
   output logic               [7:0] pc_oe_n_o,    // port C enable, low
   input  wire logic          [2:0] pd_i,         // port D pins in
   output logic               [2:0] pd_o,         // port D pins out
   output logic               [2:0] pd_oe_n_o,    // port D enable, low
   output logic         [4*8-1:0] drv_sel_o,      // drive select regs
   output logic         [4*8-1:0] imc_o           // input macrocells
);
   // configuration and data registers
   logic [7:0] ctl_reg   [2];   // control, ports A and B only
   logic [7:0] ctl_next  [2];
   logic [7:0] dir_reg   [4];   // direction per port
   logic [7:0] dir_next  [4];
   logic [7:0] drv_reg   [4];   // drive select per port
   logic [7:0] drv_next  [4];
   logic [7:0] dout_reg  [4];   // output data per port
   logic [7:0] dout_next [4];
   logic [7:0] vm_reg;          // memory_mapping_register
   logic [7:0] vm_next;
   logic [7:0] rdata_reg;       // registered read data
   logic [7:0] rdata_next;
   // pin stage registers
   logic [7:0] pa_reg, pb_reg, pc_reg, pa_oe_reg, pb_oe_reg, pc_oe_reg;
   logic [7:0] pa_nx, pb_nx, pc_nx, pa_oe_nx, pb_oe_nx, pc_oe_nx;
   logic [2:0] pd_reg, pd_oe_reg, pd_nx, pd_oe_nx;
   logic [7:0] hdata_reg, hdata_next;   // port A value to host
   logic       tp_reg, tp_next;         // test port enable
   // datapath
   logic [pom_pkg::ADDR_W-1:0] addr_q;  // latched host address
   logic [7:0] a_addr, b_addr;          // address bits per port
   logic [7:0] a_ok, b_ok;              // nibble valid per port
   logic [7:0] a_out, b_out, c_out, a_oe, b_oe, c_oe;
   logic [2:0] d_out, d_oe;
   logic [7:0] a_fin, b_fin, c_fin, d_fin;  // pins forced to input
   logic [7:0] pd_w;                        // port D pins, widened
   logic       periph_on;                   // peripheral buffer active
   logic       nonmux;                      // non-multiplexed host

   assign nonmux = (bus_type_i == pom_pkg::BUS_NONMUX);
   assign pd_w   = {5'h00, pd_i};

   // address latch: strobe loads it, non-mux host follows every cycle
   pom_strobe_latch #(.W(pom_pkg::ADDR_W)) u_addr (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .strobe_i  (addr_strobe_i | nonmux),      // see RULE21
      .d_i       (host_addr_i),
      .q_o       (addr_q)
   );

   // input macrocells catch address inputs on the strobe
   pom_strobe_latch #(.W(32)) u_imc (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .strobe_i  (addr_strobe_i),               // see RULE11
      .d_i       ({pd_w, pc_i, pb_i, pa_i}),
      .q_o       (imc_o)
   );

   // nibble map of latched address per host bus type
   always_comb begin
      a_addr = addr_q[7:0];
      b_addr = addr_q[7:0];
      a_ok   = pom_pkg::NIB_ALL;
      b_ok   = pom_pkg::NIB_ALL;
      case (bus_type_i)
         pom_pkg::BUS_MUX_GENERIC: begin        // see RULE10
            a_ok = pom_pkg::NIB_ALL;
            b_ok = pom_pkg::NIB_ALL;
         end
         pom_pkg::BUS_MUX_WIDE: begin           // see RULE10
            a_ok   = pom_pkg::NIB_HI;
            b_addr = {4'h0, addr_q[11:8]};
            b_ok   = pom_pkg::NIB_LO;
         end
         pom_pkg::BUS_MUX_PAGED: begin          // see RULE10
            a_ok   = pom_pkg::NIB_NONE;
            b_addr = addr_q[15:8];
         end
         pom_pkg::BUS_NONMUX: begin             // see RULE9
            a_ok = pom_pkg::NIB_NONE;
         end
         default: begin
            a_ok = pom_pkg::NIB_NONE;
            b_ok = pom_pkg::NIB_NONE;
         end
      endcase
   end

   // address and decode inputs are never driven, save on port A in data-port or peripheral mode; test pins are released
   assign a_fin = pld_a_i.addr_in | pld_a_i.dec_use;  // see RULE12
   assign b_fin = pld_b_i.addr_in | pld_b_i.dec_use;  // see RULE12
   assign c_fin = pld_c_i.addr_in | pld_c_i.dec_use
                | (tp_reg ? JTAG_PINS : 8'h00);       // see RULE17
   assign d_fin = pld_d_i.addr_in | pld_d_i.dec_use;  // see RULE12

   pom_port_drv #(.W(8)) u_drv_a (
      .dir_i (dir_reg[pom_pkg::PA]), .ctl_i (ctl_reg[pom_pkg::PA]),
      .dout_i (dout_reg[pom_pkg::PA]), .oe_term_i (pld_a_i.oe_term),
      .mc_out_i (pld_a_i.mc_out), .mc_def_i (pld_a_i.mc_def),
      .addr_i (a_addr), .addr_ok_i (a_ok), .force_in_i (a_fin),
      .out_o (a_out), .oe_o (a_oe)
   );
   pom_port_drv #(.W(8)) u_drv_b (
      .dir_i (dir_reg[pom_pkg::PB]), .ctl_i (ctl_reg[pom_pkg::PB]),
      .dout_i (dout_reg[pom_pkg::PB]), .oe_term_i (pld_b_i.oe_term),
      .mc_out_i (pld_b_i.mc_out), .mc_def_i (pld_b_i.mc_def),
      .addr_i (b_addr), .addr_ok_i (b_ok), .force_in_i (b_fin),
      .out_o (b_out), .oe_o (b_oe)
   );
   // ports C and D have no control register: tie it low
   pom_port_drv #(.W(8)) u_drv_c (
      .dir_i (dir_reg[pom_pkg::PC]), .ctl_i (8'h00),     // see RULE4
      .dout_i (dout_reg[pom_pkg::PC]), .oe_term_i (pld_c_i.oe_term),
      .mc_out_i (pld_c_i.mc_out), .mc_def_i (pld_c_i.mc_def),
      .addr_i (8'h00), .addr_ok_i (8'h00), .force_in_i (c_fin),
      .out_o (c_out), .oe_o (c_oe)
   );
   pom_port_drv #(.W(3)) u_drv_d (
      .dir_i (dir_reg[pom_pkg::PD][2:0]), .ctl_i (3'h0), // see RULE4
      .dout_i (dout_reg[pom_pkg::PD][2:0]),
      .oe_term_i (pld_d_i.oe_term[2:0]),
      .mc_out_i (pld_d_i.mc_out[2:0]), .mc_def_i (pld_d_i.mc_def[2:0]),
      .addr_i (3'h0), .addr_ok_i (3'h0), .force_in_i (d_fin[2:0]),
      .out_o (d_out), .oe_o (d_oe)
   );

   assign periph_on = vm_reg[pom_pkg::MEMMAP_PERIPH_BIT];  // see RULE14

   // pin stage: port A overrides by priority, test port enable
   always_comb begin
      pa_nx    = a_out;
      pa_oe_nx = a_oe;
      hdata_next = hdata_reg;
      if (data_port_en_i) begin                    // see RULE13 see RULE22
         pa_nx      = host_data_i;
         pa_oe_nx   = {8{host_wr_i}};
         hdata_next = pa_i;
      end else if (periph_on) begin                // see RULE14
         pa_nx      = host_data_i;
         pa_oe_nx   = {8{host_wr_i & (psel_a_i | psel_b_i)}}; // see RULE15
         hdata_next = pa_i;
      end
      pb_nx    = b_out;
      pb_oe_nx = b_oe;
      pc_nx    = c_out;
      pc_oe_nx = c_oe;
      pd_nx    = d_out;
      pd_oe_nx = d_oe;
      tp_next  = test_sel_term_i | test_cfg_en_i | test_run_en_i; // see RULE18
   end

   // host register writes and read-back
   always_comb begin
      ctl_next  = ctl_reg;
      dir_next  = dir_reg;
      drv_next  = drv_reg;
      dout_next = dout_reg;
      vm_next   = vm_reg;
      rdata_next = 8'h00;
      if (reg_req_i.wr) begin
         case (reg_req_i.sel)
            pom_pkg::SEL_CTL_A: ctl_next[0] = reg_req_i.wdata; // see RULE1
            pom_pkg::SEL_CTL_B: ctl_next[1] = reg_req_i.wdata;
            pom_pkg::SEL_DIR_A: dir_next[0] = reg_req_i.wdata; // see RULE19
            pom_pkg::SEL_DIR_B: dir_next[1] = reg_req_i.wdata;
            pom_pkg::SEL_DIR_C: dir_next[2] = reg_req_i.wdata;
            pom_pkg::SEL_DIR_D:
               dir_next[3] = reg_req_i.wdata & pom_pkg::PORTD_MASK;
            pom_pkg::SEL_DRV_A: drv_next[0] = reg_req_i.wdata;
            pom_pkg::SEL_DRV_B: drv_next[1] = reg_req_i.wdata;
            pom_pkg::SEL_DRV_C: drv_next[2] = reg_req_i.wdata;
            pom_pkg::SEL_DRV_D:
               drv_next[3] = reg_req_i.wdata & pom_pkg::PORTD_MASK;
            pom_pkg::SEL_OUT_A: dout_next[0] = reg_req_i.wdata; // see RULE2
            pom_pkg::SEL_OUT_B: dout_next[1] = reg_req_i.wdata;
            pom_pkg::SEL_OUT_C: dout_next[2] = reg_req_i.wdata;
            pom_pkg::SEL_OUT_D:
               dout_next[3] = reg_req_i.wdata & pom_pkg::PORTD_MASK;
            pom_pkg::SEL_MEMMAP: vm_next = reg_req_i.wdata;
            default: vm_next = vm_reg;            // read-only selectors
         endcase
      end
      case (reg_req_i.sel)
         pom_pkg::SEL_CTL_A: rdata_next = ctl_reg[0];
         pom_pkg::SEL_CTL_B: rdata_next = ctl_reg[1];
         pom_pkg::SEL_DIR_A: rdata_next = dir_reg[0];
         pom_pkg::SEL_DIR_B: rdata_next = dir_reg[1];
         pom_pkg::SEL_DIR_C: rdata_next = dir_reg[2];
         pom_pkg::SEL_DIR_D: rdata_next = dir_reg[3];
         pom_pkg::SEL_DRV_A: rdata_next = drv_reg[0];
         pom_pkg::SEL_DRV_B: rdata_next = drv_reg[1];
         pom_pkg::SEL_DRV_C: rdata_next = drv_reg[2];
         pom_pkg::SEL_DRV_D: rdata_next = drv_reg[3];
         pom_pkg::SEL_OUT_A: rdata_next = dout_reg[0];
         pom_pkg::SEL_OUT_B: rdata_next = dout_reg[1];
         pom_pkg::SEL_OUT_C: rdata_next = dout_reg[2];
         pom_pkg::SEL_OUT_D: rdata_next = dout_reg[3];
         pom_pkg::SEL_IN_A:  rdata_next = pa_i;    // see RULE3
         pom_pkg::SEL_IN_B:  rdata_next = pb_i;
         pom_pkg::SEL_IN_C:  rdata_next = pc_i;
         pom_pkg::SEL_IN_D:  rdata_next = pd_w;
         pom_pkg::SEL_EN_A:  rdata_next = pa_oe_reg;
         pom_pkg::SEL_EN_B:  rdata_next = pb_oe_reg;
         pom_pkg::SEL_EN_C:  rdata_next = pc_oe_reg;
         pom_pkg::SEL_EN_D:  rdata_next = {5'h00, pd_oe_reg};
         pom_pkg::SEL_MEMMAP: rdata_next = vm_reg;
         default: rdata_next = 8'h00;
      endcase
   end

   // register stage for configuration, pins and read data
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         for (int p = 0; p < 4; p++) begin
            dir_reg[p]  <= pom_pkg::REG_RST;   // see RULE20
            drv_reg[p]  <= pom_pkg::REG_RST;
            dout_reg[p] <= pom_pkg::REG_RST;
         end
         ctl_reg[0] <= pom_pkg::REG_RST;
         ctl_reg[1] <= pom_pkg::REG_RST;
         vm_reg     <= pom_pkg::REG_RST;
         rdata_reg  <= 8'h00;
         hdata_reg  <= 8'h00;
         {pa_reg, pb_reg, pc_reg, pd_reg} <= '0;
         {pa_oe_reg, pb_oe_reg, pc_oe_reg, pd_oe_reg} <= '0;
         tp_reg <= 1'b0;
      end else begin
         dir_reg  <= dir_next;
         drv_reg  <= drv_next;
         dout_reg <= dout_next;
         ctl_reg  <= ctl_next;
         vm_reg   <= vm_next;
         rdata_reg <= rdata_next;
         hdata_reg <= hdata_next;
         {pa_reg, pb_reg, pc_reg, pd_reg} <= {pa_nx, pb_nx, pc_nx, pd_nx};
         {pa_oe_reg, pb_oe_reg, pc_oe_reg, pd_oe_reg} <=
            {pa_oe_nx, pb_oe_nx, pc_oe_nx, pd_oe_nx};
         tp_reg <= tp_next;
      end
   end

   assign reg_rdata_o    = rdata_reg;
   assign host_data_o    = hdata_reg;
   assign test_port_en_o = tp_reg;
   assign pa_o = pa_reg;
   assign pb_o = pb_reg;
   assign pc_o = pc_reg;
   assign pd_o = pd_reg;
   assign pa_oe_n_o = ~pa_oe_reg;
   assign pb_oe_n_o = ~pb_oe_reg;
   assign pc_oe_n_o = ~pc_oe_reg;
   assign pd_oe_n_o = ~pd_oe_reg;
   assign drv_sel_o = {drv_reg[3], drv_reg[2], drv_reg[1], drv_reg[0]};

   // checks on the multiplexer behaviour
   sequence s_dp_write;
      data_port_en_i && host_wr_i;
   endsequence
   sequence s_dp_drive;
      (pa_oe_n_o == 8'h00) && (pa_o == $past(host_data_i));
   endsequence

   property p_reset_zero;
      @(posedge clk_i) sys_rst_i |=>
         (ctl_reg[0] == 8'h00) && (dir_reg[2] == 8'h00) && (vm_reg == 8'h00);
   endproperty
   a_reset_zero: assert property (p_reset_zero) // see RULE20
      else $error("config register not zero after reset");

   property p_mcu_out;
      @(posedge clk_i) disable iff (sys_rst_i)
      dir_reg[2][7] && !pld_c_i.mc_def[7] && !c_fin[7]
         |=> !pc_oe_n_o[7] && (pc_o[7] == $past(dout_reg[2][7]));
   endproperty
   a_mcu_out: assert property (p_mcu_out) // see RULE2
      else $error("mcu output pin does not follow data register");

   property p_oe_or;
      @(posedge clk_i) disable iff (sys_rst_i)
      (d_fin[2:0] == 3'h0) |=>
         pd_oe_n_o == ~($past(dir_reg[3][2:0]) | $past(pld_d_i.oe_term[2:0]));
   endproperty
   a_oe_or: assert property (p_oe_or) // see RULE16
      else $error("port D enable is not direction OR term");

   property p_periph_tri;
      @(posedge clk_i) disable iff (sys_rst_i)
      periph_on && !data_port_en_i && !psel_a_i && !psel_b_i
         |=> pa_oe_n_o == 8'hFF;
   endproperty
   a_periph_tri: assert property (p_periph_tri) // see RULE15
      else $error("peripheral buffer driven without select");

   property p_data_port;
      @(posedge clk_i) disable iff (sys_rst_i) s_dp_write |=> s_dp_drive;
   endproperty
   a_data_port: assert property (p_data_port) // see RULE13
      else $error("data port does not carry host data");

   property p_addr_hold;
      @(posedge clk_i) disable iff (sys_rst_i)
      !addr_strobe_i && !nonmux |=> $stable(addr_q);
   endproperty
   a_addr_hold: assert property (p_addr_hold) // see RULE21
      else $error("latched address moved between strobes");

   property p_nonmux_b;
      @(posedge clk_i) disable iff (sys_rst_i)
      nonmux && (ctl_reg[1] == 8'hFF) && (dir_reg[1] == 8'hFF)
         && (b_fin == 8'h00) |=> pb_o == $past(addr_q[7:0]);
   endproperty
   a_nonmux_b: assert property (p_nonmux_b) // see RULE9
      else $error("port B does not show low address byte");

   property p_test_en;
      @(posedge clk_i) disable iff (sys_rst_i)
      test_sel_term_i || test_cfg_en_i || test_run_en_i |=> test_port_en_o;
   endproperty
   a_test_en: assert property (p_test_en) // see RULE18
      else $error("test port not enabled by its source");

   property p_imc_cap;
      @(posedge clk_i) disable iff (sys_rst_i)
      addr_strobe_i |=> imc_o[15:8] == $past(pb_i);
   endproperty
   a_imc_cap: assert property (p_imc_cap) // see RULE11
      else $error("input macrocell missed address on strobe");
endmodule
`default_nettype wire

// [src/pom_strobe_latch.sv]
// strobe-loaded holding register, used for address and input capture
`timescale 1ns/1ps
`default_nettype none
module pom_strobe_latch #(
   parameter int unsigned W = 8       // data width
) (
   input  wire logic         clk_i,      // bus clock
   input  wire logic         sys_rst_i,  // synchronous reset, high
   input  wire logic         strobe_i,   // load enable
   input  wire logic [W-1:0] d_i,        // value to capture
   output logic      [W-1:0] q_o         // held value
);
   logic [W-1:0] q_reg;   // held value
   logic [W-1:0] q_next;  // next held value

   // load on strobe, otherwise hold
   always_comb begin
      q_next = q_reg;
      if (strobe_i) begin
         q_next = d_i;
      end
   end

   // register only
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign q_o = q_reg;
endmodule
`default_nettype wire

// [testbench/pom_partner.sv]
// far-side pin model: peripheral drives only pins the device leaves free
`timescale 1ns/1ps
`default_nettype none
module pom_partner #(
   parameter int unsigned W = 8  // pins modelled
) (
   input  wire logic [W-1:0] dev_i,   // device pin values
   input  wire logic [W-1:0] oe_n_i,  // device enables, low drives
   input  wire logic [W-1:0] ext_i,   // value the peripheral offers
   output logic      [W-1:0] pin_o    // resolved pin level
);
   // peripheral yields to a driving device pin
   assign pin_o = (oe_n_i & ext_i) | (~oe_n_i & dev_i);
endmodule
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the port mode multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_i = 1'b0, sys_rst_i = 1'b1, stb = 1'b0, hwr = 1'b0;
   logic dpe = 1'b0, psa = 1'b0, psb = 1'b0, ten;
   logic [2:0] t = 3'h0, pdi, pdo, pdn;
   logic [7:0] hd = 8'h00, ea = 8'h00, ec = 8'h00, rd, hdo;
   logic [7:0] pai, pao, pan, pbi, pbo, pbn, pci, pco, pcn;
   logic [31:0] dsel, input_macrocell;                           // drive select, cells
   logic [15:0] addr = 16'h0000;                     // host address
   pom_pkg::pom_reg_req_t req = '0;                  // register access
   pom_pkg::pom_bus_t bus = pom_pkg::BUS_MUX_GENERIC; // host bus flavour
   pom_pkg::pom_pld_t pa_t = '0, pb_t = '0, pc_t = '0, pd_t = '0;
   int miscompares = 0, num_checks = 0;
   logic [20:0] rows [6] = '{{pom_pkg::SEL_CTL_A, 16'h5A5A},
      {pom_pkg::SEL_DIR_D, 16'hFF07}, {pom_pkg::SEL_DRV_C, 16'h3C3C},
      {pom_pkg::SEL_EN_A, 16'h7700}, {pom_pkg::SEL_CTL_A, 16'h0000},
      {pom_pkg::SEL_DIR_D, 16'h0000}};
   logic [7:0] bx [4] = '{8'h34, 8'h02, 8'h12, 8'hCD}; // per bus type
   pom_port_mux uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(req),
      .reg_rdata_o(rd), .bus_type_i(bus), .host_addr_i(addr),
      .addr_strobe_i(stb), .host_data_i(hd), .host_wr_i(hwr),
      .host_data_o(hdo), .data_port_en_i(dpe), .psel_a_i(psa),
      .psel_b_i(psb), .pld_a_i(pa_t), .pld_b_i(pb_t), .pld_c_i(pc_t),
      .pld_d_i(pd_t), .test_sel_term_i(t[0]), .test_cfg_en_i(t[1]),
      .test_run_en_i(t[2]), .test_port_en_o(ten), .pa_i(pai), .pa_o(pao),
      .pa_oe_n_o(pan), .pb_i(pbi), .pb_o(pbo), .pb_oe_n_o(pbn),
      .pc_i(pci), .pc_o(pco), .pc_oe_n_o(pcn), .pd_i(pdi), .pd_o(pdo),
      .pd_oe_n_o(pdn), .drv_sel_o(dsel), .imc_o(input_macrocell));
   pom_partner #(.W(8)) pa_m (.dev_i(pao), .oe_n_i(pan),
      .ext_i(ea), .pin_o(pai));
   pom_partner #(.W(8)) pb_m (.dev_i(pbo), .oe_n_i(pbn),
      .ext_i(ea), .pin_o(pbi));
   pom_partner #(.W(8)) pc_m (.dev_i(pco), .oe_n_i(pcn),
      .ext_i(ec), .pin_o(pci));
   pom_partner #(.W(3)) pd_m (.dev_i(pdo), .oe_n_i(pdn),
      .ext_i(3'h5), .pin_o(pdi));
   // clock, 5 ns period
   initial forever #2.5 clk_i = ~clk_i;
   // compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // one-cycle register write, then one idle cycle before the next request
   task automatic wr(input pom_pkg::pom_reg_sel_t s, input logic [7:0] d);
      req = '{1'b1, s, d};
      @(negedge clk_i) req.wr = 1'b0;
      @(negedge clk_i);
   endtask
   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // watchdog well beyond the expected run
   initial begin
      #5000;
      miscompares++;
      end_sim();
   end
   // main sequence
   initial begin
      step(3);
      sys_rst_i = 1'b0;
      chk(pan & pbn & pcn, 8'hFF);
      foreach (rows[i]) begin
         wr(pom_pkg::pom_reg_sel_t'(rows[i][20:16]), rows[i][15:8]);
         @(negedge clk_i) chk(rd, rows[i][7:0]);
      end
      $display("register table done");
      wr(pom_pkg::SEL_OUT_C, 8'h81);
      wr(pom_pkg::SEL_DIR_C, 8'h81);
      ec = 8'h3C;
      req.sel = pom_pkg::SEL_IN_C;
      step(2);
      chk(pcn, 8'h7E);
      chk(pco & 8'h81, 8'h81);
      chk(rd, 8'hBD);
      pd_t = '{8'h02, 8'h02, 8'h02, 8'h00, 8'h00}; // pin 1 macrocell owned
      step(1);
      chk({5'h00, pdn}, 8'h05);
      chk({5'h00, pdo}, 8'h02);
      $display("io mode done");
      wr(pom_pkg::SEL_CTL_B, 8'hFF);
      wr(pom_pkg::SEL_DIR_B, 8'hFF);
      addr = 16'h1234;
      stb = 1'b1;
      step(1);
      stb = 1'b0;
      chk(input_macrocell[23:16], 8'hBD);
      addr = 16'hABCD;
      foreach (bx[i]) begin
         bus = pom_pkg::pom_bus_t'(i);
         step(2);
         chk(pbo, bx[i]);
      end
      bus = pom_pkg::BUS_MUX_GENERIC;
      wr(pom_pkg::SEL_DIR_B, 8'h00);
      step(1);
      chk(pbn, 8'hFF);
      $display("address out done");
      wr(pom_pkg::SEL_MEMMAP, 8'h80);
      hwr = 1'b1;
      hd = 8'hA5;
      step(1);
      chk(pan, 8'hFF);
      psa = 1'b1;
      step(1);
      chk(pan, 8'h00);
      chk(pao, 8'hA5);
      psa = 1'b0;
      dpe = 1'b1;
      hd = 8'h3C;
      step(2);
      chk(pan, 8'h00);
      chk(hdo, 8'h3C);
      $display("data paths done");
      for (int i = 0; i < 3; i++) begin
         t = 3'(1 << i);
         step(1);
         chk({7'h00, ten}, 8'h01);
      end
      chk(pcn, 8'h7F);
      pc_t.dec_use = 8'h80;
      step(1);
      chk(pcn, 8'hFF);
      sys_rst_i = 1'b1;
      step(1);
      sys_rst_i = 1'b0;
      chk(pcn & pan, 8'hFF);
      chk(dsel[23:16], 8'h00);
      $display("test port and reset done");
      end_sim();
   end
endmodule
`default_nettype wire
